// File: rtl/sprst_pkg.sv
// Shared constants and carrier types for the serial port pass-through block.
package sprst_pkg;
    localparam int unsigned SYNC_STAGES   = 2;
    localparam int unsigned WORD_BITS     = 8;
    localparam int unsigned ASYNC_INPUTS  = 6;
    // Idle pin levels while the synchroniser is cleared: supply low, select high.
    localparam logic [ASYNC_INPUTS-1:0] SYNC_RESET = 6'h34;
    localparam int unsigned PIN_1         = 0;
    localparam int unsigned PIN_2         = 1;
    localparam int unsigned PIN_3         = 2;
    localparam int unsigned PIN_4         = 3;
    localparam logic        DOUT_RESET    = 1'b0;
    localparam logic        PIN_RESET     = 1'b0;

    typedef struct packed {
        logic push_pull;
        logic active_high;
    } sprst_rst_cfg_type;

    typedef struct packed {
        logic out;
        logic oe;
    } sprst_pin_type;
endpackage

// File: rtl/sprst_sync.sv
// Two-stage synchroniser for a vector of inputs from outside the clock domain.
`timescale 1ns/10ps
module sprst_sync #(
    parameter int unsigned      WIDTH       = 1,
    parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
    input  wire logic             i_clk,
    input  wire logic             i_nrst,
    input  wire logic [WIDTH-1:0] i_async,
    output logic      [WIDTH-1:0] o_sync
);
    logic [WIDTH-1:0] stage1;

    // The first stage is read only by the second stage.
    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            // Cleared stages show idle levels, so no false edge follows reset.
            stage1 <= RESET_VALUE;
            o_sync <= RESET_VALUE;
        end else begin
            stage1 <= i_async;
            o_sync <= stage1;
        end
    end
endmodule

// File: rtl/sprst_top.sv
// Serial host port with analog-side pass-through and supply reset outputs.
`timescale 1ns/10ps
module sprst_top #(
    parameter int unsigned WORD_BITS = sprst_pkg::WORD_BITS
) (
    input  wire logic                         i_clk,
    input  wire logic                         i_nrst,
    input  wire logic                         i_sclk,
    input  wire logic                         i_din,
    input  wire logic                         i_cs_n,
    input  wire logic                         i_analog_pin_1,
    input  wire logic                         i_dvdd_below_low,
    input  wire logic                         i_dvdd_below_high,
    input  wire logic [3:0]                   i_pass_mode,
    input  wire sprst_pkg::sprst_rst_cfg_type i_rst_low_cfg,
    input  wire sprst_pkg::sprst_rst_cfg_type i_rst_high_cfg,
    input  wire logic                         i_status_irq,
    input  wire logic [WORD_BITS-1:0]         i_tx_word,
    output logic                              o_dout,
    output logic                              o_dout_oe,
    output logic                              o_analog_pin_2,
    output logic                              o_analog_pin_2_oe,
    output logic                              o_analog_pin_3,
    output logic                              o_analog_pin_3_oe,
    output logic                              o_analog_pin_4,
    output logic                              o_analog_pin_4_oe,
    output logic                              o_reset_out_low_threshold,
    output logic                              o_reset_out_low_threshold_oe,
    output logic                              o_reset_out_high_threshold,
    output logic                              o_reset_out_high_threshold_oe,
    output logic [WORD_BITS-1:0]              o_rx_word,
    output logic                              o_rx_valid
);
    localparam int unsigned CW = $clog2(WORD_BITS + 1);

    logic [sprst_pkg::ASYNC_INPUTS-1:0] sync_q;
    logic                               sclk_s;
    logic                               din_s;
    logic                               cs_s;
    logic                               apin1_s;
    logic                               below_low_s;
    logic                               below_high_s;
    logic                               sclk_p;
    logic                               cs_p;
    logic                               rise;
    logic                               fall;
    logic                               cs_fall;
    logic [WORD_BITS-1:0]               rx_sh;
    logic [WORD_BITS-1:0]               tx_sh;
    logic [CW-1:0]                      bit_cnt;
    sprst_pkg::sprst_pin_type           next_rst_low;
    sprst_pkg::sprst_pin_type           next_rst_high;

    sprst_sync #(
        .WIDTH       (sprst_pkg::ASYNC_INPUTS),
        .RESET_VALUE (sprst_pkg::SYNC_RESET)
    ) u_sync (
        .i_clk   (i_clk),
        .i_nrst  (i_nrst),
        .i_async ({i_dvdd_below_high, i_dvdd_below_low, i_analog_pin_1,
                   i_cs_n, i_din, i_sclk}),
        .o_sync  (sync_q)
    );

    assign sclk_s       = sync_q[0];
    assign din_s        = sync_q[1];
    assign cs_s         = sync_q[2];
    assign apin1_s      = sync_q[3];
    assign below_low_s  = sync_q[4];
    assign below_high_s = sync_q[5];
    assign rise         = sclk_s & ~sclk_p;
    assign fall         = ~sclk_s & sclk_p;
    assign cs_fall      = ~cs_s & cs_p;

    function automatic sprst_pkg::sprst_pin_type rst_pin(
        input logic                         below,
        input sprst_pkg::sprst_rst_cfg_type cfg,
        input logic                         irq
    );
        sprst_pkg::sprst_pin_type p;
        if (below) begin
            p.out = 1'b0;
            p.oe  = 1'b1;
        end else if (cfg.push_pull) begin
            p.out = cfg.active_high ? irq : ~irq;
            p.oe  = 1'b1;
        end else begin
            p.out = 1'b0;
            p.oe  = 1'b0;
        end
        return p;
    endfunction

    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            sclk_p <= 1'b0;
            cs_p   <= 1'b1;
        end else begin
            sclk_p <= sclk_s;
            cs_p   <= cs_s;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            rx_sh      <= '0;
            bit_cnt    <= '0;
            o_rx_word  <= '0;
            o_rx_valid <= 1'b0;
        end else begin
            o_rx_valid <= 1'b0;
            if (cs_s) begin
                bit_cnt <= '0;
            end else if (rise) begin
                rx_sh <= {rx_sh[WORD_BITS-2:0], din_s};
                if (bit_cnt == CW'(WORD_BITS - 1)) begin
                    bit_cnt    <= '0;
                    o_rx_word  <= {rx_sh[WORD_BITS-2:0], din_s};
                    o_rx_valid <= 1'b1;
                end else begin
                    bit_cnt <= bit_cnt + CW'(1);
                end
            end
        end
    end

    // falling edge launch.
    // Bit one is placed at select so the host sees it before the first rise.
    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            tx_sh  <= '0;
            o_dout <= sprst_pkg::DOUT_RESET;
        end else if (cs_s) begin
            o_dout <= i_pass_mode[sprst_pkg::PIN_1] ? apin1_s : sprst_pkg::DOUT_RESET;
        end else if (cs_fall) begin
            o_dout <= i_tx_word[WORD_BITS-1];
            tx_sh  <= {i_tx_word[WORD_BITS-2:0], 1'b0};
        end else if (fall) begin
            o_dout <= tx_sh[WORD_BITS-1];
            tx_sh  <= {tx_sh[WORD_BITS-2:0], 1'b0};
        end else if (rise && bit_cnt == CW'(WORD_BITS - 1)) begin
            tx_sh <= i_tx_word;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            o_dout_oe <= 1'b0;
        end else begin
            o_dout_oe <= ~cs_s | i_pass_mode[sprst_pkg::PIN_1];
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            o_analog_pin_2    <= sprst_pkg::PIN_RESET;
            o_analog_pin_2_oe <= 1'b0;
            o_analog_pin_3    <= sprst_pkg::PIN_RESET;
            o_analog_pin_3_oe <= 1'b0;
            o_analog_pin_4    <= sprst_pkg::PIN_RESET;
            o_analog_pin_4_oe <= 1'b0;
        end else begin
            o_analog_pin_2    <= cs_s & din_s;
            o_analog_pin_2_oe <= i_pass_mode[sprst_pkg::PIN_2];
            o_analog_pin_3    <= cs_s & sclk_s;
            o_analog_pin_3_oe <= i_pass_mode[sprst_pkg::PIN_3];
            o_analog_pin_4    <= ~cs_s;
            o_analog_pin_4_oe <= i_pass_mode[sprst_pkg::PIN_4];
        end
    end

    always_comb begin
        next_rst_low  = rst_pin(below_low_s, i_rst_low_cfg, i_status_irq);
        next_rst_high = rst_pin(below_high_s, i_rst_high_cfg, i_status_irq);
    end

    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            o_reset_out_low_threshold     <= 1'b0;
            o_reset_out_low_threshold_oe  <= 1'b1;
            o_reset_out_high_threshold    <= 1'b0;
            o_reset_out_high_threshold_oe <= 1'b1;
        end else begin
            o_reset_out_low_threshold     <= next_rst_low.out;
            o_reset_out_low_threshold_oe  <= next_rst_low.oe;
            o_reset_out_high_threshold    <= next_rst_high.out;
            o_reset_out_high_threshold_oe <= next_rst_high.oe;
        end
    end

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_nrst);

    property p_launch_fall;
        (fall && !cs_s && !cs_fall) |=> (o_dout == $past(tx_sh[WORD_BITS-1]));
    endproperty
    a_launch_fall: assert property (p_launch_fall) else $error("dout not launched on fall");

    property p_float;
        (cs_s && !i_pass_mode[sprst_pkg::PIN_1]) |=> !o_dout_oe;
    endproperty
    a_float: assert property (p_float) else $error("dout driven while deselected");

    property p_clk_ignore;
        (cs_s && rise) |=> $stable(rx_sh) && (bit_cnt == '0);
    endproperty
    a_clk_ignore: assert property (p_clk_ignore) else $error("clock used deselected");

    property p_clk_pass;
        (cs_s && i_pass_mode[sprst_pkg::PIN_3]) |=> o_analog_pin_3_oe
            && (o_analog_pin_3 == $past(sclk_s));
    endproperty
    a_clk_pass: assert property (p_clk_pass) else $error("clock not forwarded");

    property p_capture;
        (rise && !cs_s) |=> (rx_sh[0] == $past(din_s));
    endproperty
    a_capture: assert property (p_capture) else $error("input not captured");

    property p_din_pass;
        (cs_s && i_pass_mode[sprst_pkg::PIN_2]) |=> o_analog_pin_2_oe
            && (o_analog_pin_2 == $past(din_s));
    endproperty
    a_din_pass: assert property (p_din_pass) else $error("data not forwarded");

    property p_sel_low;
        (cs_s && i_pass_mode[sprst_pkg::PIN_4]) |=> o_analog_pin_4_oe && !o_analog_pin_4;
    endproperty
    a_sel_low: assert property (p_sel_low) else $error("pin 4 not low");

    property p_rst_low;
        below_low_s |=> o_reset_out_low_threshold_oe && !o_reset_out_low_threshold;
    endproperty
    a_rst_low: assert property (p_rst_low) else $error("low reset not asserted");

    property p_rst_high;
        below_high_s |=> o_reset_out_high_threshold_oe && !o_reset_out_high_threshold;
    endproperty
    a_rst_high: assert property (p_rst_high) else $error("high reset not asserted");

    property p_word_done;
        (rise && !cs_s && bit_cnt == CW'(WORD_BITS - 1)) |=> o_rx_valid ##1 !o_rx_valid;
    endproperty
    a_word_done: assert property (p_word_done) else $error("word strobe wrong");

    c_word: cover property (o_rx_valid);
    c_pass: cover property (cs_s && i_pass_mode == 4'hF && rise);
    c_irq: cover property (i_rst_low_cfg.push_pull && o_reset_out_low_threshold);
endmodule

// File: verification/sprst_host.sv
// Behavioural serial host that drives clock, data and select.
`timescale 1ns/10ps
module sprst_host (
    input  wire logic i_clk,
    input  wire logic i_dout,
    output logic      o_sclk,
    output logic      o_din,
    output logic      o_cs_n
);
    initial begin
        o_sclk = 1'b0;
        o_din  = 1'b0;
        o_cs_n = 1'b1;
    end
    // The low phase is longer so the launched bit has settled at the rise.
    // stable data, held select.
    task automatic xfer(input logic [7:0] tx, input int nbits, input logic hold,
                        output logic [7:0] rx);
        rx = 8'h00;
        @(negedge i_clk);
        o_cs_n = 1'b0;
        for (int i = 7; i > 7 - nbits; i--) begin
            o_din = tx[i];
            repeat (5) @(negedge i_clk);
            rx[i] = i_dout;
            o_sclk = 1'b1;
            repeat (3) @(negedge i_clk);
            o_sclk = 1'b0;
        end
        repeat (2) @(negedge i_clk);
        o_cs_n = hold ? 1'b0 : 1'b1;
        o_din = ~o_din;
    endtask
    task automatic drive(input logic d, input logic s);
        o_din  = d;
        o_sclk = s;
    endtask
endmodule

// File: verification/tb_top.sv
// Self-checking bench for the serial port pass-through block.
`timescale 1ns/10ps
module tb_top;
    logic                         i_clk = 1'b0;
    logic                         i_nrst = 1'b0;
    logic                         i_sclk, i_din, i_cs_n, dout_pin;
    logic                         i_analog_pin_1 = 1'b0;
    logic                         i_dvdd_below_low = 1'b1;
    logic                         i_dvdd_below_high = 1'b1;
    logic [3:0]                   i_pass_mode = 4'h0;
    sprst_pkg::sprst_rst_cfg_type i_rst_low_cfg = '0;
    sprst_pkg::sprst_rst_cfg_type i_rst_high_cfg = '0;
    logic                         i_status_irq = 1'b0;
    logic [7:0]                   i_tx_word = 8'h00;
    logic                         o_dout, o_dout_oe, o_analog_pin_2, o_analog_pin_2_oe;
    logic                         o_analog_pin_3, o_analog_pin_3_oe;
    logic                         o_analog_pin_4, o_analog_pin_4_oe;
    logic                         o_reset_out_low_threshold, o_reset_out_low_threshold_oe;
    logic                         o_reset_out_high_threshold, o_reset_out_high_threshold_oe;
    logic [7:0]                   o_rx_word, rx, rx2, d, v;
    logic                         o_rx_valid;
    logic [15:0]                  seed = 16'h476c;
    logic [7:0]                   exp_q[$];
    int                           num_errors = 0;
    int                           checked = 0;
    always #12.5 i_clk = ~i_clk;
    // A released output shows the inverse of its last value, so stale data is never taken.
    assign dout_pin = (o_dout_oe === 1'b1) ? o_dout : ~o_dout;
    sprst_host i_sprst_host (.i_clk, .i_dout(dout_pin), .o_sclk(i_sclk), .o_din(i_din),
                             .o_cs_n(i_cs_n));
    sprst_top i_sprst_top (.i_clk, .i_nrst, .i_sclk, .i_din, .i_cs_n, .i_analog_pin_1,
        .i_dvdd_below_low, .i_dvdd_below_high, .i_pass_mode, .i_rst_low_cfg,
        .i_rst_high_cfg, .i_status_irq, .i_tx_word, .o_dout, .o_dout_oe, .o_analog_pin_2,
        .o_analog_pin_2_oe, .o_analog_pin_3, .o_analog_pin_3_oe, .o_analog_pin_4,
        .o_analog_pin_4_oe, .o_reset_out_low_threshold, .o_reset_out_low_threshold_oe,
        .o_reset_out_high_threshold, .o_reset_out_high_threshold_oe, .o_rx_word, .o_rx_valid);
    function automatic logic [15:0] lfsr_next(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic rnd();
        seed = lfsr_next(seed);
    endtask
    task automatic test_done();
        $display("checked %0d mismatches %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic word(input logic [7:0] tx, input logic [7:0] dv, input logic hold);
        i_tx_word = tx;
        exp_q.push_back(dv);
        i_sprst_host.xfer(dv, 8, hold, rx);
        check("dout_word", rx, tx);
    endtask
    always @(negedge i_clk) begin
        if (o_rx_valid === 1'b1) begin
            if (exp_q.size() == 0) begin
                check("rx_spurious", 8'h01, 8'h00);
            end else begin
                check("rx_word", o_rx_word, exp_q.pop_front());
            end
        end
    end
    initial begin
        #200_000;
        num_errors++;
        test_done();
    end
    initial begin
        repeat (6) @(negedge i_clk);
        check("rst_dout_oe", o_dout_oe, 1'b0);
        check("rst_pin_oe", o_reset_out_low_threshold_oe, 1'b1);
        check("rst_pin_out", o_reset_out_high_threshold, 1'b0);
        repeat (2) @(negedge i_clk);
        i_nrst = 1'b1;
        repeat (4) @(negedge i_clk);
        for (int k = 0; k < 5; k++) begin
            rnd();
            word(seed[7:0], seed[15:8], 1'b0);
        end
        // back-to-back words reload the next word.
        fork
            word(8'h80, 8'h01, 1'b1);
            begin
                // The next word must stand before the eighth rise reloads it.
                repeat (10) @(negedge i_clk);
                i_tx_word = 8'h7e;
            end
        join
        exp_q.push_back(8'hff);
        i_sprst_host.xfer(8'hff, 8, 1'b0, rx2);
        check("dout_second", rx2, 8'h7e);
        $display("test words done");
        i_sprst_host.xfer(8'ha5, 3, 1'b0, rx);
        word(8'h3c, 8'hc3, 1'b0);
        repeat (4) @(negedge i_clk);
        // partial word lost, full word intact.
        check("rx_pending", 8'(exp_q.size()), 8'h00);
        $display("test partial done");
        for (int k = 0; k < 24; k++) begin
            rnd();
            i_pass_mode = seed[3:0];
            i_analog_pin_1 = seed[4];
            i_sprst_host.drive(seed[5], seed[6]);
            repeat (6) @(negedge i_clk);
            // output floats unless pin 1 passes.
            check("dout_oe", o_dout_oe, seed[0]);
            if (seed[0]) check("dout_pass", o_dout, seed[4]);
            check("pin2_oe", o_analog_pin_2_oe, seed[1]);
            if (seed[1]) check("pin2", o_analog_pin_2, seed[5]);
            check("pin3_oe", o_analog_pin_3_oe, seed[2]);
            if (seed[2]) check("pin3", o_analog_pin_3, seed[6]);
            check("pin4_oe", o_analog_pin_4_oe, seed[3]);
            if (seed[3]) check("pin4", o_analog_pin_4, 1'b0);
        end
        i_sprst_host.drive(1'b0, 1'b0);
        $display("test pass done");
        for (int k = 0; k < 16; k++) begin
            v = 8'(k);
            {i_dvdd_below_low, i_rst_low_cfg, i_status_irq} = v[3:0];
            {i_dvdd_below_high, i_rst_high_cfg} = ~v[3:1];
            repeat (6) @(negedge i_clk);
            d = {6'h00, v[3] | v[2], v[3] ? 1'b0 : (v[1] ? v[0] : ~v[0])};
            check("rlow_oe", o_reset_out_low_threshold_oe, d[1]);
            if (d[1]) check("rlow", o_reset_out_low_threshold, d[0]);
            d = {6'h00, ~v[3] | ~v[2], ~v[3] ? 1'b0 : (~v[1] ? v[0] : ~v[0])};
            check("rhigh_oe", o_reset_out_high_threshold_oe, d[1]);
            if (d[1]) check("rhigh", o_reset_out_high_threshold, d[0]);
        end
        $display("test resets done");
        test_done();
    end
endmodule
